// file: design/ret_stack.sv
`timescale 1ns/10ps
`default_nettype none
module ret_stack (
  // Clock and reset
  input wire logic    clk,
  input wire logic    rst,
  // Core side
  ret_stack_if.stack  stk
);
  import retrot_pkg::*;

  logic [PC_W-1:0] mem_q [STACK_D];
  logic [SP_W-1:0] sp_q;
  logic [SP_W-1:0] sp_d;

  // Pointer starts one below entry zero so the first push lands there.
  always_comb begin
    sp_d = sp_q;
    if (stk.push) begin
      sp_d = sp_q + 4'h1;
    end else if (stk.pop) begin
      sp_d = sp_q - 4'h1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sp_q <= SP_RST;
    end else begin
      sp_q <= sp_d;
    end
  end

  // Storage carries no reset; overflow wraps and overwrites silently.
  always_ff @(posedge clk) begin
    if (stk.push) begin
      mem_q[sp_d] <= stk.push_addr;
    end
  end

  assign stk.top_of_stack = mem_q[sp_q];
endmodule
`default_nettype wire

// file: design/ret_stack_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ret_stack_if;
  import retrot_pkg::*;
  logic            push;
  logic            pop;
  logic [PC_W-1:0] push_addr;
  logic [PC_W-1:0] top_of_stack;
  modport core  (output push, output pop, output push_addr,
                 input top_of_stack);
  modport stack (input push, input pop, input push_addr,
                 output top_of_stack);
endinterface
`default_nettype wire

// file: design/retrot_pkg.sv
// Notes on behaviour
// - Interrupt return pops stack into program counter.
// - Interrupt return sets global interrupt enable bit.
// - Literal return loads immediate into working register.
// - Literal return pops stack, two cycles, flags kept.
// - Plain return pops stack, two cycles, nothing else.
// - Rotate left through carry by one bit.
// - Destination bit picks working or file register.
package retrot_pkg;
  localparam int PC_W       = 15;
  localparam int SP_W       = 4;
  localparam int STACK_D    = 16;
  localparam int OP_W       = 14;
  localparam int DATA_W     = 8;
  localparam int FADDR_W    = 7;
  localparam int INT_EN_POS = 7;
  localparam int DEST_POS   = 7;
  localparam logic [OP_W-1:0] OP_INT_RET     = 14'h0009;
  localparam logic [OP_W-1:0] OP_RET         = 14'h0008;
  localparam logic [5:0]      OP_LIT_RET_HI  = 6'h34;
  localparam logic [5:0]      OP_ROT_LEFT_HI = 6'h0D;
  localparam logic [PC_W-1:0] PC_RST   = 15'h0000;
  localparam logic [PC_W-1:0] PC_STEP  = 15'h0001;
  localparam logic [SP_W-1:0] SP_RST   = 4'hF;
  localparam logic [DATA_W-1:0] W_RST  = 8'h00;
  localparam logic [DATA_W-1:0] IC_RST = 8'h00;
  localparam logic               C_RST     = 1'b0;
  localparam logic               BUSY_RST  = 1'b0;
  localparam logic               FWE_RST   = 1'b0;
  localparam logic [FADDR_W-1:0] FADDR_RST = 7'h00;
  localparam logic [DATA_W-1:0]  FWD_RST   = 8'h00;
  localparam int RET_CYCLES = 2;

  typedef enum logic [0:0] {
    ST_EXEC  = 1'b0,
    ST_FLUSH = 1'b1
  } exec_state_t;
endpackage

// file: design/return_and_rotate_exec.sv
`timescale 1ns/10ps
`default_nettype none
module return_and_rotate_exec (
  // Clock and reset
  input  wire logic                         clk,
  input  wire logic                         rst,
  // Instruction stream
  input  wire logic                         op_valid,
  input  wire logic [retrot_pkg::OP_W-1:0]  opcode,
  // Call path into the return stack
  input  wire logic                         call_push,
  input  wire logic [retrot_pkg::PC_W-1:0]  call_addr,
  // File register read port
  input  wire logic [retrot_pkg::DATA_W-1:0] file_rdata,
  // Core state outputs
  output logic [retrot_pkg::PC_W-1:0]       pc,
  output logic [retrot_pkg::DATA_W-1:0]     working_reg,
  output logic                              carry,
  output logic [retrot_pkg::DATA_W-1:0]     interrupt_control_reg,
  output logic                              busy,
  // File register write port
  output logic                              file_we,
  output logic [retrot_pkg::FADDR_W-1:0]    file_addr,
  output logic [retrot_pkg::DATA_W-1:0]     file_wdata
);
  import retrot_pkg::*;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  ret_stack_if sif ();

  logic               take;
  logic               is_int_ret;
  logic               is_ret;
  logic               is_lit_ret;
  logic               is_rot_left;
  logic               dest_file;
  logic               pop;
  logic [5:0]         op_hi;
  logic [DATA_W-1:0]  lit_val;
  logic [FADDR_W-1:0] file_sel;
  logic [DATA_W-1:0]  rot_res;
  logic               rot_c;

  exec_state_t        st_q;
  exec_state_t        st_d;
  logic               busy_q;
  logic               busy_d;
  logic [PC_W-1:0]    pc_q;
  logic [PC_W-1:0]    pc_d;
  logic [DATA_W-1:0]  w_q;
  logic [DATA_W-1:0]  w_d;
  logic               c_q;
  logic               c_d;
  logic [DATA_W-1:0]  ic_q;
  logic [DATA_W-1:0]  ic_d;
  logic               fwe_q;
  logic               fwe_d;
  logic [FADDR_W-1:0] fa_q;
  logic [FADDR_W-1:0] fa_d;
  logic [DATA_W-1:0]  fwd_q;
  logic [DATA_W-1:0]  fwd_d;

  // Field slices of the instruction word.
  assign op_hi    = opcode[OP_W-1:OP_W-6];
  assign lit_val  = opcode[DATA_W-1:0];
  assign file_sel = opcode[FADDR_W-1:0];

  // A second-cycle flush ignores whatever word arrives alongside it.
  assign take        = op_valid && (st_q == ST_EXEC);
  assign is_int_ret  = take && (opcode == OP_INT_RET);
  assign is_ret      = take && (opcode == OP_RET);
  assign is_lit_ret  = take && (op_hi == OP_LIT_RET_HI);
  assign is_rot_left = take && (op_hi == OP_ROT_LEFT_HI);
  assign dest_file   = opcode[DEST_POS];
  assign pop         = is_int_ret || is_ret || is_lit_ret;

  // Old carry enters bit 0, old bit 7 leaves into carry.
  assign rot_res = {file_rdata[DATA_W-2:0], c_q};
  assign rot_c   = file_rdata[DATA_W-1];

  // ----------------------------------------------------------------
  // Stack
  // ----------------------------------------------------------------
  // Pop wins over a push in the same cycle; that call is then lost.
  assign sif.pop       = pop;
  assign sif.push      = call_push && !pop;
  assign sif.push_addr = call_addr;

  ret_stack u_stack (
    .clk (clk),
    .rst (rst),
    .stk (sif)
  );

  // ----------------------------------------------------------------
  // Sequencing
  // ----------------------------------------------------------------
  // Every return spends its second cycle here, refusing new words.
  always_comb begin
    st_d   = st_q;
    busy_d = 1'b0;
    case (st_q)
      ST_EXEC: begin
        if (pop) begin
          st_d   = ST_FLUSH;
          busy_d = 1'b1;
        end
      end
      ST_FLUSH: begin
        st_d = ST_EXEC;
      end
      default: begin
        st_d = ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q   <= ST_EXEC;
      busy_q <= BUSY_RST;
    end else begin
      st_q   <= st_d;
      busy_q <= busy_d;
    end
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  // Returns reload from the stack; any other accepted word steps on.
  always_comb begin
    pc_d = pc_q;
    if (pop) begin
      pc_d = sif.top_of_stack;
    end else if (take) begin
      pc_d = pc_q + PC_STEP;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_q <= PC_RST;
    end else begin
      pc_q <= pc_d;
    end
  end

  // ----------------------------------------------------------------
  // Working register, carry and interrupt control
  // ----------------------------------------------------------------
  always_comb begin
    w_d  = w_q;
    c_d  = c_q;
    ic_d = ic_q;
    if (is_int_ret) begin
      ic_d[INT_EN_POS] = 1'b1;
    end
    if (is_lit_ret) begin
      w_d = lit_val;
    end
    // Returns never touch carry, so status survives the flush.
    if (is_rot_left) begin
      c_d = rot_c;
      if (!dest_file) begin
        w_d = rot_res;
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      w_q  <= W_RST;
      c_q  <= C_RST;
      ic_q <= IC_RST;
    end else begin
      w_q  <= w_d;
      c_q  <= c_d;
      ic_q <= ic_d;
    end
  end

  // ----------------------------------------------------------------
  // File register write
  // ----------------------------------------------------------------
  // The strobe lasts one cycle; address and data hold for a slow sink.
  always_comb begin
    fwe_d = 1'b0;
    fa_d  = fa_q;
    fwd_d = fwd_q;
    if (is_rot_left && dest_file) begin
      fwe_d = 1'b1;
      fa_d  = file_sel;
      fwd_d = rot_res;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      fwe_q <= FWE_RST;
      fa_q  <= FADDR_RST;
      fwd_q <= FWD_RST;
    end else begin
      fwe_q <= fwe_d;
      fa_q  <= fa_d;
      fwd_q <= fwd_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Each output is a bare register, so the core sees no decode delay.
  assign pc                    = pc_q;
  assign working_reg           = w_q;
  assign carry                 = c_q;
  assign interrupt_control_reg = ic_q;
  assign busy                  = busy_q;
  assign file_we               = fwe_q;
  assign file_addr             = fa_q;
  assign file_wdata            = fwd_q;
endmodule
`default_nettype wire

// file: testbench/return_and_rotate_exec_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module return_and_rotate_exec_asserts
  import retrot_pkg::*;
(
  // Clock and reset
  input wire logic              clk,
  input wire logic              rst,
  // Inputs
  input wire logic              op_valid,
  input wire logic [OP_W-1:0]   opcode,
  input wire logic              call_push,
  input wire logic [PC_W-1:0]   call_addr,
  input wire logic [DATA_W-1:0] file_rdata,
  // Outputs
  input wire logic [PC_W-1:0]   pc,
  input wire logic [DATA_W-1:0] working_reg,
  input wire logic              carry,
  input wire logic [DATA_W-1:0] interrupt_control_reg,
  input wire logic              busy,
  input wire logic              file_we,
  input wire logic [FADDR_W-1:0] file_addr,
  input wire logic [DATA_W-1:0] file_wdata
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire tk = op_valid & ~busy;
  wire rl = tk & (opcode[13:8] == 6'h0D);
  wire pops = tk & ((opcode == 14'h0008) | (opcode == 14'h0009) |
                    (opcode[13:8] == 6'h34));
  a_ret_busy: assert property (tk && opcode == OP_RET
    |=> busy ##1 !busy) else $error("return not two cycles");
  a_ret_flags: assert property (tk && opcode == OP_RET
    |=> $stable(carry) && $stable(working_reg)
    && $stable(interrupt_control_reg)) else $error("return changed state");
  a_pop_order: assert property (call_push && !pops
    ##1 !call_push && !pops ##1 (tk && opcode == OP_RET)
    |=> pc == $past(call_addr, 3)) else $error("pop gave wrong address");
  a_irq_enable: assert property (tk && opcode == 14'h0009
    |=> interrupt_control_reg[7] && busy) else $error("enable not set");
  a_lit_load: assert property (tk && opcode[13:8] == 6'h34
    |=> working_reg == $past(opcode[7:0]) && busy && $stable(carry))
    else $error("literal not loaded");
  a_rot_carry: assert property (rl
    |=> carry == $past(file_rdata[7])) else $error("carry wrong");
  a_rot_file: assert property (rl && opcode[7]
    |=> file_we && file_addr == $past(opcode[6:0])
    && file_wdata == {$past(file_rdata[6:0]), $past(carry)}
    ##1 file_we == $past(rl && opcode[7]))
    else $error("file write wrong");
  a_rot_work: assert property (rl && !opcode[7]
    |=> !file_we && working_reg == {$past(file_rdata[6:0]), $past(carry)})
    else $error("working result wrong");
  c_ret: cover property (tk && opcode == OP_RET);
  c_lit: cover property (tk && opcode[13:8] == 6'h34);
  c_rot: cover property (rl && opcode[7]);
  c_irq: cover property (tk && opcode == 14'h0009);
endmodule
bind return_and_rotate_exec return_and_rotate_exec_asserts chk (.clk, .rst,
  .op_valid, .opcode, .call_push, .call_addr, .file_rdata, .pc, .working_reg,
  .carry, .interrupt_control_reg, .busy, .file_we, .file_addr, .file_wdata);
`default_nettype wire

// file: testbench/return_and_rotate_exec_bench.sv
`timescale 1ns/10ps
`default_nettype none
module return_and_rotate_exec_bench;
  import retrot_pkg::*;
  logic clk = 1'b0, rst = 1'b1, op_valid = 1'b0, call_push = 1'b0;
  logic [OP_W-1:0] opcode = 14'h0000;
  logic [PC_W-1:0] call_addr = 15'h0000, pc;
  logic [DATA_W-1:0] file_rdata = 8'h00, working_reg, interrupt_control_reg;
  logic [DATA_W-1:0] file_wdata;
  logic [FADDR_W-1:0] file_addr;
  logic carry, busy, file_we;
  int errors = 0, samples_checked = 0;
  always #4 clk = ~clk;
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t %h %h", $time, a, b); end end
  return_and_rotate_exec dut (.clk, .rst, .op_valid, .opcode, .call_push,
    .call_addr, .file_rdata, .pc, .working_reg, .carry,
    .interrupt_control_reg, .busy, .file_we, .file_addr, .file_wdata);
  task give_verdict;
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task push(input logic [PC_W-1:0] a);
    @(posedge clk); call_push <= 1'b1; call_addr <= a;
    @(posedge clk); call_push <= 1'b0;
  endtask
  // Waits out a flush cycle, since opcodes offered while busy are dropped.
  task issue(input logic [OP_W-1:0] op, input logic [DATA_W-1:0] fd);
    int i;
    for (i = 0; busy !== 1'b0; i++) begin
      if (i > 8) begin errors++; give_verdict; end
      @(posedge clk); #1;
    end
    @(posedge clk); op_valid <= 1'b1; opcode <= op; file_rdata <= fd;
    @(posedge clk); op_valid <= 1'b0;
    #1;
  endtask
  task t_nested;
    push(15'h0123); push(15'h4567);
    issue(OP_RET, 8'h00);
    `CHK(pc, 15'h4567)
    `CHK(busy, 1'b1)
    issue(14'h34AB, 8'h00);
    `CHK(pc, 15'h0123)
    `CHK(working_reg, 8'hAB)
    `CHK({carry, interrupt_control_reg[7]}, 2'h0)
  endtask
  task t_irq_ret;
    push(15'h7FFE); issue(14'h0009, 8'h00);
    `CHK(pc, 15'h7FFE)
    `CHK({busy, interrupt_control_reg[7]}, 2'h3)
    push(15'h0222); issue(OP_RET, 8'h00);
    `CHK({pc, interrupt_control_reg[7]}, 16'h0445)
  endtask
  task t_rotate;
    issue({6'h0D, 1'b0, 7'h11}, 8'hE6);
    `CHK({working_reg, carry, file_we}, 10'h332)
    issue({6'h0D, 1'b1, 7'h15}, 8'h01);
    `CHK({file_we, file_addr, file_wdata, carry}, 17'h12A06)
    `CHK(working_reg, 8'hCC)
    @(posedge clk); #1;
    `CHK(file_we, 1'b0)
    issue({6'h0D, 1'b0, 7'h00}, 8'h80);
    `CHK({working_reg, carry}, 9'h001)
    push(15'h0456); issue(14'h3455, 8'h00);
    `CHK({pc, working_reg}, 23'h045655)
    `CHK({carry, interrupt_control_reg[7]}, 2'h3)
  endtask
  initial begin
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    `CHK({pc, working_reg, carry, interrupt_control_reg, busy, file_we}, 34'h0)
    t_nested;
    t_irq_ret;
    t_rotate;
    give_verdict;
  end
endmodule
`default_nettype wire
